//--- bench/dsf_drive_model.sv
// drive side model answering parameter handshakes
`timescale 1ns/1ns
module dsf_drive_model (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic [3:0] hs_out_in,
    input wire logic [3:0] delay_in,
    input wire logic two_word_in,
    output logic [3:0] hs_in_out,
    output logic read_done_out,
    output logic read_2word_out
);
    logic [3:0] wait_cnt;
    logic busy;
    logic done;
    // ************************************************
    // parameter read answer
    // ************************************************
    // start on request bit, finish delay_in+1 cycles after the start, echo handshake
    always_ff @(posedge sys_clk_in) begin
        done <= 1'b0;
        if (sys_rst_in || !hs_out_in[0]) begin
            busy <= 1'b0;
            hs_in_out <= 4'h0;
        end else if (!busy && !hs_in_out[0]) begin
            busy <= 1'b1;
            wait_cnt <= delay_in;
        end else if (busy && wait_cnt == 4'h0) begin
            busy <= 1'b0;
            done <= 1'b1;
            hs_in_out <= hs_out_in;
        end else if (busy) begin
            wait_cnt <= wait_cnt - 4'h1;
        end
    end
    // width only meaningful with the done pulse, inverted otherwise
    assign read_done_out = done;
    assign read_2word_out = done ? two_word_in : !two_word_in;
endmodule : dsf_drive_model

//--- bench/dsf_flag_bank_tb.sv
// self-checking bench for the special flag bank
`timescale 1ns/1ns
module dsf_flag_bank_tb;
    logic sys_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdat = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic net_var = 1'b0;
    logic net_mode = 1'b0;
    logic [2:0] pulses = 3'h0;
    logic [8:0] dstat = 9'h000;
    logic [13:0] ostat = 14'h0000;
    logic sfault = 1'b0;
    logic [3:0] dly = 4'h0;
    logic two_w = 1'b0;
    logic [15:0] rdat, term, v;
    logic [3:0] hso, hsi;
    logic rdone, r2w, pw2, cwr, crd, fst, rst_s, fterm, rterm;
    logic ostop, freset, shold;
    logic [4:0] nvi;
    int error_cnt = 0;
    int check_count = 0;
    int nxb[5] = '{dsf_pkg::B_NX1, dsf_pkg::B_STP, dsf_pkg::B_NX3,
                   dsf_pkg::B_NX4, dsf_pkg::B_NX5};
    // clock at 50 MHz
    always #10 sys_clk_in = ~sys_clk_in;
    dsf_flag_bank uut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
        .addr_in(addr), .wr_data_in(wdat), .wr_in(wr), .rd_in(rd),
        .rd_data_out(rdat), .net_variant_in(net_var),
        .network_mode_in(net_mode), .scan_start_in(pulses[0]),
        .drive_status_in(dstat), .out_func_status_in(ostat),
        .safety_fault_in(sfault), .param_read_done_in(rdone),
        .param_read_2word_in(r2w), .param_access_handshake_in(hsi),
        .param_access_handshake_out(hso), .param_write_2word_out(pw2),
        .ext_clock_set_in(pulses[1]), .param_clock_set_in(pulses[2]),
        .clock_write_out(cwr), .clock_read_en_out(crd),
        .terminal_state_out(term), .forward_start_input_out(fst),
        .reverse_start_input_out(rst_s), .fwd_terminal_out(fterm),
        .rev_terminal_out(rterm), .output_stop_input_out(ostop),
        .fault_reset_input_out(freset), .stop_hold_input_out(shold),
        .network_virtual_input_out(nvi));
    dsf_drive_model drive (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
        .hs_out_in(hso), .delay_in(dly), .two_word_in(two_w),
        .hs_in_out(hsi), .read_done_out(rdone), .read_2word_out(r2w));
    // ************************************************
    // access tasks
    // ************************************************
    task automatic chk(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk_in);
        addr <= a;
        wdat <= d;
        wr <= 1'b1;
        @(posedge sys_clk_in);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge sys_clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk_in);
        rd <= 1'b0;
        #1;
        d = rdat;
    endtask : rd_reg
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask : tick
    // one-cycle pulse on scan, peripheral set or parameter set
    task automatic strobe(input logic [2:0] m);
        @(posedge sys_clk_in);
        pulses <= m;
        @(posedge sys_clk_in);
        pulses <= 3'h0;
    endtask : strobe
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results
    // ************************************************
    // test sequence
    // ************************************************
    initial begin
        repeat (4) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        for (int a = 0; a < 5; a++) begin
            rd_reg(4'(a), v);
            chk("reset word", v, 16'h0000);
        end
        $display("test reset done");
        wr_reg(dsf_pkg::A_CTRL, 16'h0a00);
        tick(2);
        chk("output stop", 16'(ostop), 16'h0001);
        chk("fault reset", 16'(freset), 16'h0001);
        wr_reg(dsf_pkg::A_CTRL, 16'h0400);
        wr_reg(dsf_pkg::A_TWORD, 16'h0201);
        tick(2);
        chk("stop hold", 16'(shold), 16'h0001);
        chk("output stop off", 16'(ostop), 16'h0000);
        rd_reg(dsf_pkg::A_CTRL, v);
        chk("ctrl held", v, 16'h0400);
        wr_reg(dsf_pkg::A_CFG, 16'h0001);
        tick(2);
        chk("word source", term, 16'h0201);
        chk("word stop", 16'(ostop), 16'h0001);
        wr_reg(dsf_pkg::A_CFG, 16'h0000);
        tick(2);
        chk("flag source", term, 16'h0400);
        $display("test terminal done");
        wr_reg(dsf_pkg::A_CTRL, 16'h0003);
        tick(2);
        chk("start local", 16'({fterm, rterm, fst, rst_s}), 16'h000c);
        @(posedge sys_clk_in);
        net_mode <= 1'b1;
        tick(2);
        chk("start net", 16'({fterm, rterm, fst, rst_s}), 16'h0003);
        net_mode <= 1'b0;
        net_var <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            wr_reg(dsf_pkg::A_CTRL, 16'h0001 << nxb[i]);
            tick(2);
            chk("net input", 16'(nvi), 16'h0001 << i);
            chk("no stop hold", 16'(shold), 16'h0000);
        end
        @(posedge sys_clk_in);
        net_var <= 1'b0;
        $display("test network done");
        dstat <= 9'h155;
        ostat <= 14'h2a5a;
        strobe(3'h1);
        dstat <= 9'h0aa;
        ostat <= 14'h15a5;
        rd_reg(dsf_pkg::A_DSTAT, v);
        chk("drive snap", v, 16'h0155);
        rd_reg(dsf_pkg::A_OSTAT, v);
        chk("out snap", v, 16'h2a5a);
        wr_reg(dsf_pkg::A_DSTAT, 16'hffff);
        rd_reg(dsf_pkg::A_DSTAT, v);
        chk("status ro", v, 16'h0155);
        sfault <= 1'b1;
        strobe(3'h1);
        rd_reg(dsf_pkg::A_OSTAT, v);
        chk("out refresh", v, 16'h15a5);
        rd_reg(dsf_pkg::A_MSTAT, v);
        chk("safety fail", 16'(v[0]), 16'h0000);
        sfault <= 1'b0;
        strobe(3'h1);
        rd_reg(dsf_pkg::A_MSTAT, v);
        chk("safety ok", 16'(v[0]), 16'h0001);
        rd_reg(4'h8, v);
        chk("unmapped", v, 16'h0000);
        $display("test status done");
        for (int k = 0; k < 3; k++) begin
            dly <= k ? 4'h5 : 4'h0;
            two_w <= k[0];
            wr_reg(dsf_pkg::A_HSO, 16'h0005);
            for (int t = 0; t <= 20; t++) begin
                tick(1);
                if (rdone === 1'b1) break;
                if (t == 20) begin
                    error_cnt++;
                    results();
                end
            end
            rd_reg(dsf_pkg::A_MSTAT, v);
            chk("width notice", 16'(v[1]), 16'(k[0]));
            chk("handshake in", 16'(v[7:4]), 16'h0005);
            chk("handshake out", 16'(hso), 16'h0005);
            wr_reg(dsf_pkg::A_HSO, 16'h0000);
        end
        wr_reg(dsf_pkg::A_CFG, 16'h0002);
        tick(2);
        chk("write width", 16'(pw2), 16'h0001);
        $display("test parameter done");
        wr_reg(dsf_pkg::A_REQ, 16'h0001);
        tick(1);
        chk("clock write", 16'(cwr), 16'h0001);
        chk("no read", 16'(crd), 16'h0000);
        tick(1);
        chk("clock write end", 16'(cwr), 16'h0000);
        for (int m = 0; m < 3; m++) begin
            if (m > 0) begin
                wr_reg(dsf_pkg::A_REQ, 16'h0000);
                strobe(3'h1 << m);
            end
            rd_reg(dsf_pkg::A_MSTAT, v);
            chk("set done", 16'(v[2]), 16'h0001);
            wr_reg(dsf_pkg::A_REQ, 16'h0002);
            tick(1);
            chk("read enable", 16'(crd), 16'h0001);
            rd_reg(dsf_pkg::A_MSTAT, v);
            chk("done cleared", 16'(v[2]), 16'h0000);
        end
        $display("test clock done");
        results();
    end
endmodule : dsf_flag_bank_tb

//--- design/dsf_clock_ctl.sv
// clock set and read request handling
`timescale 1ns/1ns
module dsf_clock_ctl (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic set_req_in,
    input wire logic read_req_in,
    input wire logic ext_clock_set_in,
    input wire logic param_clock_set_in,
    output logic clock_write_out,
    output logic clock_read_en_out,
    output logic clock_set_done_flag_out
);
    logic set_req_d;
    logic read_req_d;
    logic set_evt;
    logic read_rise;
    logic next_done;

    // ************************************************
    // edge detection and done flag
    // ************************************************
    // request edges, set events from any source
    assign set_evt = ext_clock_set_in | param_clock_set_in
        | (set_req_in & ~set_req_d);
    assign read_rise = read_req_in & ~read_req_d;
    assign next_done = set_evt ? 1'b1 :
        (read_rise ? 1'b0 : clock_set_done_flag_out);
    // read only while request is on
    assign clock_read_en_out = read_req_in;

    // registers
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            set_req_d <= 1'b0;
            read_req_d <= 1'b0;
            clock_write_out <= 1'b0;
            clock_set_done_flag_out <= 1'b0;
        end else begin
            set_req_d <= set_req_in;
            read_req_d <= read_req_in;
            clock_write_out <= set_req_in & ~set_req_d;
            clock_set_done_flag_out <= next_done;
        end
    end

    // ************************************************
    // checks
    // ************************************************
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (sys_rst_in);

    sequence set_rise_s;
        !set_req_in ##1 set_req_in;
    endsequence
    sequence read_rise_s;
        !read_req_in ##1 read_req_in;
    endsequence

    a_done_on_set: assert property (
        set_rise_s |=> clock_set_done_flag_out && clock_write_out)
        else $error("clock set not flagged");
    a_done_clr_read: assert property (
        (read_rise_s ##0 !ext_clock_set_in && !param_clock_set_in
            && $stable(set_req_in)) |=> !clock_set_done_flag_out)
        else $error("done flag not cleared");
    a_read_enable: assert property (
        clock_read_en_out == read_req_in)
        else $error("clock read enable wrong");
endmodule : dsf_clock_ctl

//--- design/dsf_flag_bank.sv
// special flag bank between user program and drive core
`timescale 1ns/1ns
module dsf_flag_bank (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic [dsf_pkg::AW-1:0] addr_in,
    input wire logic [dsf_pkg::DW-1:0] wr_data_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [dsf_pkg::DW-1:0] rd_data_out,
    input wire logic net_variant_in,
    input wire logic network_mode_in,
    input wire logic scan_start_in,
    input wire logic [dsf_pkg::DST_W-1:0] drive_status_in,
    input wire logic [dsf_pkg::OST_W-1:0] out_func_status_in,
    input wire logic safety_fault_in,
    input wire logic param_read_done_in,
    input wire logic param_read_2word_in,
    input wire logic [dsf_pkg::HS_W-1:0] param_access_handshake_in,
    output logic [dsf_pkg::HS_W-1:0] param_access_handshake_out,
    output logic param_write_2word_out,
    input wire logic ext_clock_set_in,
    input wire logic param_clock_set_in,
    output logic clock_write_out,
    output logic clock_read_en_out,
    output logic [dsf_pkg::DW-1:0] terminal_state_out,
    output logic forward_start_input_out,
    output logic reverse_start_input_out,
    output logic fwd_terminal_out,
    output logic rev_terminal_out,
    output logic output_stop_input_out,
    output logic fault_reset_input_out,
    output logic stop_hold_input_out,
    output logic [4:0] network_virtual_input_out
);
    // ************************************************
    // decode helper
    // ************************************************
    // write hit on one register index
    function automatic logic wr_hit(
        input logic wr,
        input logic [3:0] a,
        input logic [3:0] target
    );
        wr_hit = wr && (a == target);
    endfunction : wr_hit

    // ************************************************
    // declarations
    // ************************************************
    logic [15:0] ctrl_flags;
    logic [15:0] terminal_control_word;
    logic [1:0] cfg;
    logic [1:0] req;
    logic param_width_notice_flag;
    logic [15:0] term_sel;
    logic [15:0] rd_mux;
    logic [4:0] net_map;
    logic [dsf_pkg::DST_W-1:0] drive_snap;
    logic [dsf_pkg::OST_W-1:0] out_snap;
    logic safety_monitor_flag;
    logic clock_set_done_flag;
    logic control_source_select_flag;
    logic param_width_setting_flag;
    logic clock_set_request_flag;
    logic clock_read_request_flag;
    logic wr_ctrl;
    logic wr_tword;
    logic wr_cfg;
    logic wr_req;
    logic wr_hso;

    // ************************************************
    // write decode and flag names
    // ************************************************
    assign wr_ctrl = wr_hit(wr_in, addr_in, dsf_pkg::A_CTRL);
    assign wr_tword = wr_hit(wr_in, addr_in, dsf_pkg::A_TWORD);
    assign wr_cfg = wr_hit(wr_in, addr_in, dsf_pkg::A_CFG);
    assign wr_req = wr_hit(wr_in, addr_in, dsf_pkg::A_REQ);
    assign wr_hso = wr_hit(wr_in, addr_in, dsf_pkg::A_HSO);
    assign control_source_select_flag = cfg[dsf_pkg::CFG_SRC];
    assign param_width_setting_flag = cfg[dsf_pkg::CFG_W2];
    assign clock_set_request_flag = req[dsf_pkg::REQ_SET];
    assign clock_read_request_flag = req[dsf_pkg::REQ_RD];

    // ************************************************
    // writable flag registers
    // ************************************************
    // values held until rewritten
    // control, terminal word, config, request and handshake out registers are writable
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            ctrl_flags <= dsf_pkg::CTRL_RST;
            terminal_control_word <= dsf_pkg::CTRL_RST;
            cfg <= dsf_pkg::CFG_RST;
            req <= dsf_pkg::REQ_RST;
            param_access_handshake_out <= dsf_pkg::HSO_RST;
        end else begin
            if (wr_ctrl)
                ctrl_flags <= wr_data_in;
            if (wr_tword)
                terminal_control_word <= wr_data_in;
            if (wr_cfg)
                cfg <= wr_data_in[1:0];
            if (wr_req)
                req <= wr_data_in[1:0];
            if (wr_hso)
                param_access_handshake_out <= wr_data_in[3:0];
        end
    end

    // ************************************************
    // parameter width handling
    // ************************************************
    // write width follows setting flag
    assign param_write_2word_out = param_width_setting_flag;

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in)
            param_width_notice_flag <= 1'b0;
        else if (param_read_done_in)
            param_width_notice_flag <= param_read_2word_in;
    end

    // ************************************************
    // terminal selection and mapping
    // ************************************************
    // flags or terminal word
    assign term_sel = control_source_select_flag ?
        terminal_control_word : ctrl_flags;
    // one to one network input mapping
    assign net_map = net_variant_in ?
        {term_sel[dsf_pkg::B_NX5], term_sel[dsf_pkg::B_NX4],
         term_sel[dsf_pkg::B_NX3], term_sel[dsf_pkg::B_STP],
         term_sel[dsf_pkg::B_NX1]} : 5'h00;

    // terminal registers toward the drive core
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            terminal_state_out <= dsf_pkg::CTRL_RST;
            forward_start_input_out <= 1'b0;
            reverse_start_input_out <= 1'b0;
            fwd_terminal_out <= 1'b0;
            rev_terminal_out <= 1'b0;
            output_stop_input_out <= 1'b0;
            fault_reset_input_out <= 1'b0;
            stop_hold_input_out <= 1'b0;
            network_virtual_input_out <= 5'h00;
        end else begin
            terminal_state_out <= term_sel;
            // fixed forward start in network mode
            forward_start_input_out <= network_mode_in
                & term_sel[dsf_pkg::B_FWD];
            fwd_terminal_out <= ~network_mode_in
                & term_sel[dsf_pkg::B_FWD];
            // fixed reverse start in network mode
            reverse_start_input_out <= network_mode_in
                & term_sel[dsf_pkg::B_REV];
            rev_terminal_out <= ~network_mode_in
                & term_sel[dsf_pkg::B_REV];
            output_stop_input_out <= term_sel[dsf_pkg::B_MRS];
            fault_reset_input_out <= term_sel[dsf_pkg::B_RES];
            // stop hold only on non-network variant
            stop_hold_input_out <= ~net_variant_in
                & term_sel[dsf_pkg::B_STP];
            network_virtual_input_out <= net_map;
        end
    end

    // ************************************************
    // helper blocks
    // ************************************************
    // per-scan status snapshot
    dsf_status_snap u_snap (
        .sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in),
        .scan_start_in(scan_start_in),
        .drive_status_in(drive_status_in),
        .out_status_in(out_func_status_in),
        .safety_fault_in(safety_fault_in),
        .drive_snap_out(drive_snap),
        .out_snap_out(out_snap),
        .safe_ok_out(safety_monitor_flag)
    );

    // clock request handling
    dsf_clock_ctl u_clk (
        .sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in),
        .set_req_in(clock_set_request_flag),
        .read_req_in(clock_read_request_flag),
        .ext_clock_set_in(ext_clock_set_in),
        .param_clock_set_in(param_clock_set_in),
        .clock_write_out(clock_write_out),
        .clock_read_en_out(clock_read_en_out),
        .clock_set_done_flag_out(clock_set_done_flag)
    );

    // ************************************************
    // read path
    // ************************************************
    // read mux, unmapped indices read zero
    always_comb begin
        rd_mux = 16'h0000;
        unique case (addr_in)
            dsf_pkg::A_CTRL: rd_mux = ctrl_flags;
            dsf_pkg::A_TWORD: rd_mux = terminal_control_word;
            dsf_pkg::A_CFG: rd_mux[1:0] = cfg;
            dsf_pkg::A_REQ: rd_mux[1:0] = req;
            dsf_pkg::A_HSO: rd_mux[3:0] = param_access_handshake_out;
            dsf_pkg::A_DSTAT: rd_mux[dsf_pkg::DST_W-1:0] = drive_snap;
            // one bit per assigned output function
            dsf_pkg::A_OSTAT: rd_mux[dsf_pkg::OST_W-1:0] = out_snap;
            dsf_pkg::A_MSTAT: begin
                rd_mux[dsf_pkg::MS_SAFE] = safety_monitor_flag;
                rd_mux[dsf_pkg::MS_WNOT] = param_width_notice_flag;
                rd_mux[dsf_pkg::MS_CDONE] = clock_set_done_flag;
                rd_mux[7:4] = param_access_handshake_in;
            end
            default: rd_mux = 16'h0000;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in)
            rd_data_out <= 16'h0000;
        else
            rd_data_out <= rd_in ? rd_mux : 16'h0000;
    end

    // ************************************************
    // checks
    // ************************************************
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (sys_rst_in);

    a_src_flag_path: assert property (
        !control_source_select_flag |=>
            terminal_state_out == $past(ctrl_flags))
        else $error("flag source not applied");
    a_src_word_path: assert property (
        control_source_select_flag |=>
            terminal_state_out == $past(terminal_control_word))
        else $error("word source not applied");
    a_stop_follows: assert property (
        ##1 output_stop_input_out == $past(term_sel[dsf_pkg::B_MRS]))
        else $error("output stop mismatch");
    a_reset_follows: assert property (
        ##1 fault_reset_input_out == $past(term_sel[dsf_pkg::B_RES]))
        else $error("reset terminal mismatch");
    a_hold_variant: assert property (
        net_variant_in |=> !stop_hold_input_out)
        else $error("stop hold on network variant");
    a_net_map_one: assert property (
        net_variant_in && term_sel[dsf_pkg::B_NX1] |=>
            network_virtual_input_out[0])
        else $error("network input 1 not mapped");
    a_width_notice: assert property (
        param_read_done_in |=>
            param_width_notice_flag == $past(param_read_2word_in))
        else $error("width notice wrong");
    a_width_write: assert property (
        wr_cfg |=> param_write_2word_out ==
            $past(wr_data_in[dsf_pkg::CFG_W2]))
        else $error("write width wrong");
    a_fwd_net_fixed: assert property (
        network_mode_in && term_sel[dsf_pkg::B_FWD] |=>
            forward_start_input_out && !fwd_terminal_out)
        else $error("forward start reassigned");
    a_rev_net_fixed: assert property (
        network_mode_in && term_sel[dsf_pkg::B_REV] |=>
            reverse_start_input_out && !rev_terminal_out)
        else $error("reverse start reassigned");
    a_ctrl_hold_val: assert property (
        !wr_ctrl |=> $stable(ctrl_flags))
        else $error("control flags changed unwritten");
    a_read_slot: assert property (
        !rd_in |=> rd_data_out == 16'h0000)
        else $error("read data outside slot");

    // ************************************************
    // further checks on mapping, holding and status
    // ************************************************
    a_net_map_all: assert property (
        net_variant_in |=> network_virtual_input_out == {
            $past(term_sel[dsf_pkg::B_NX5]),
            $past(term_sel[dsf_pkg::B_NX4]),
            $past(term_sel[dsf_pkg::B_NX3]),
            $past(term_sel[dsf_pkg::B_STP]),
            $past(term_sel[dsf_pkg::B_NX1])})
        else $error("network inputs not mapped");
    a_net_map_off: assert property (
        !net_variant_in |=> network_virtual_input_out == 5'h00)
        else $error("network inputs without variant");
    a_fwd_local: assert property (
        !network_mode_in && term_sel[dsf_pkg::B_FWD] |=>
            fwd_terminal_out && !forward_start_input_out)
        else $error("forward start outside network mode");
    a_rev_local: assert property (
        !network_mode_in && term_sel[dsf_pkg::B_REV] |=>
            rev_terminal_out && !reverse_start_input_out)
        else $error("reverse start outside network mode");
    a_tword_hold: assert property (
        !wr_tword |=> $stable(terminal_control_word))
        else $error("terminal word changed unwritten");
    a_hso_hold: assert property (
        !wr_hso |=> $stable(param_access_handshake_out))
        else $error("handshake outputs changed unwritten");
    a_src_reg_write: assert property (
        wr_cfg |=> control_source_select_flag ==
            $past(wr_data_in[dsf_pkg::CFG_SRC]))
        else $error("source select not stored");
    a_done_by_pulse: assert property (
        ext_clock_set_in || param_clock_set_in |=> clock_set_done_flag)
        else $error("clock set pulse not flagged");
    a_done_status: assert property (
        rd_in && addr_in == dsf_pkg::A_MSTAT |=>
            rd_data_out[dsf_pkg::MS_CDONE] == $past(clock_set_done_flag))
        else $error("done flag not readable");
    a_read_data: assert property (
        rd_in |=> rd_data_out == $past(rd_mux))
        else $error("read data not from selected word");
endmodule : dsf_flag_bank

//--- design/dsf_pkg.sv
// constants shared by the special flag bank and its helpers
package dsf_pkg;
    // ************************************************
    // register offsets, word index on the plain port
    // ************************************************
    localparam int AW = 4;
    localparam int DW = 16;
    localparam logic [3:0] A_CTRL = 4'h0;
    localparam logic [3:0] A_TWORD = 4'h1;
    localparam logic [3:0] A_CFG = 4'h2;
    localparam logic [3:0] A_REQ = 4'h3;
    localparam logic [3:0] A_HSO = 4'h4;
    localparam logic [3:0] A_DSTAT = 4'h5;
    localparam logic [3:0] A_OSTAT = 4'h6;
    localparam logic [3:0] A_MSTAT = 4'h7;
    // ************************************************
    // control word bit positions
    // ************************************************
    localparam int B_FWD = 0;
    localparam int B_REV = 1;
    localparam int B_NX1 = 8;
    localparam int B_MRS = 9;
    localparam int B_STP = 10;
    localparam int B_RES = 11;
    localparam int B_NX3 = 12;
    localparam int B_NX4 = 13;
    localparam int B_NX5 = 14;
    // ************************************************
    // config, request and misc status fields
    // ************************************************
    localparam int CFG_SRC = 0;
    localparam int CFG_W2 = 1;
    localparam int REQ_SET = 0;
    localparam int REQ_RD = 1;
    localparam int MS_SAFE = 0;
    localparam int MS_WNOT = 1;
    localparam int MS_CDONE = 2;
    localparam int MS_HSI = 4;
    // ************************************************
    // widths and reset values
    // ************************************************
    localparam int DST_W = 9;
    localparam int OST_W = 14;
    localparam int HS_W = 4;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [1:0] CFG_RST = 2'h0;
    localparam logic [1:0] REQ_RST = 2'h0;
    localparam logic [3:0] HSO_RST = 4'h0;
endpackage : dsf_pkg

//--- design/dsf_status_snap.sv
// per-scan snapshot of drive status and safety monitor
`timescale 1ns/1ns
module dsf_status_snap (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic scan_start_in,
    input wire logic [dsf_pkg::DST_W-1:0] drive_status_in,
    input wire logic [dsf_pkg::OST_W-1:0] out_status_in,
    input wire logic safety_fault_in,
    output logic [dsf_pkg::DST_W-1:0] drive_snap_out,
    output logic [dsf_pkg::OST_W-1:0] out_snap_out,
    output logic safe_ok_out
);
    // ************************************************
    // snapshot registers
    // ************************************************
    // refresh each scan
    // output flags kept even without option
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            drive_snap_out <= '0;
            out_snap_out <= '0;
            safe_ok_out <= 1'b0;
        end else if (scan_start_in) begin
            drive_snap_out <= drive_status_in;
            out_snap_out <= out_status_in;
            safe_ok_out <= ~safety_fault_in;
        end
    end

    // ************************************************
    // checks
    // ************************************************
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (sys_rst_in);

    a_snap_take_hold: assert property (
        scan_start_in |=> (out_snap_out == $past(out_status_in))
            && (drive_snap_out == $past(drive_status_in)))
        else $error("status snapshot not taken");
    a_safe_flag_inv: assert property (
        scan_start_in |=> safe_ok_out == !$past(safety_fault_in))
        else $error("safety flag wrong");
endmodule : dsf_status_snap
